// ==== include/adccs_defines.svh ====
/*
 Offsets, field positions, reset values and timing counts of the converter
 sequencer. Assumes a 6-bit I/O address space with 8-bit registers.
*/
`ifndef ADCCS_DEFINES_SVH
`define ADCCS_DEFINES_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADCCS_OFS_CTRL_A 6'h06
`define ADCCS_OFS_CTRL_B 6'h03
`define ADCCS_OFS_SEL 6'h10
`define ADCCS_OFS_RES_LO 6'h04
`define ADCCS_OFS_RES_HI 6'h05
// ----------------------------------------------------------------
// Field positions and reset byte
// ----------------------------------------------------------------
`define ADCCS_A_EN 7
`define ADCCS_A_START 6
`define ADCCS_A_AUTO 5
`define ADCCS_A_FLAG 4
`define ADCCS_A_IE 3
`define ADCCS_B_FREE 0
`define ADCCS_SEL_REF 6
`define ADCCS_RST_BYTE 8'h00
// ----------------------------------------------------------------
// Conversion profiles in half converter-clock cycles
// ----------------------------------------------------------------
`define ADCCS_FIRST_LEN 6'd50
`define ADCCS_FIRST_SH 6'd27
`define ADCCS_NORM_LEN 6'd26
`define ADCCS_NORM_SH 6'd3
`define ADCCS_AUTO_LEN 6'd27
`define ADCCS_AUTO_SH 6'd4
`define ADCCS_FREE_LEN 6'd28
`define ADCCS_FREE_SH 6'd5
`endif

// ==== include/adccs_pkg.sv ====
/*
 Types shared by both ends of the converter sequencer.
 Assumes adccs_defines.svh is compiled alongside.
*/
package adccs_pkg;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ADCCS_IDLE, ADCCS_WAIT, ADCCS_CONV} adccs_state_t;
   typedef enum logic [1:0] {ADCCS_FIRST, ADCCS_NORMAL, ADCCS_AUTO, ADCCS_FREE} adccs_kind_t;
   typedef enum logic [1:0] {ADCCS_H_IDLE, ADCCS_H_STROBE, ADCCS_H_CAPT} adccs_hstate_t;

   // Divide ratio for a divider select code; codes 0 and 1 both give 2
   function automatic logic [7:0] adccs_ratio(input logic [2:0] sel);
      adccs_ratio = (sel == 3'h0) ? 8'h02 : (8'h01 << sel);
   endfunction
endpackage

// ==== include/adccs_if.sv ====
/*
 I/O register bus plus trigger, sleep and interrupt lines between the CPU
 side and the converter sequencer. Assumes one shared clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface adccs_if;
   logic [5:0] io_addr;
   logic [7:0] io_wdata;
   logic io_wr;
   logic io_rd;
   logic [7:0] io_rdata;
   logic trig_src;
   logic sleep_quiet;
   logic conv_irq;
   modport dev (input io_addr, io_wdata, io_wr, io_rd, trig_src, sleep_quiet,
                output io_rdata, conv_irq);
   modport host (output io_addr, io_wdata, io_wr, io_rd, trig_src, sleep_quiet,
                 input io_rdata, conv_irq);
endinterface
`default_nettype wire

// ==== verilog/adccs_prescaler.sv ====
/*
 Converter clock prescaler: emits rise and fall enable pulses of the
 converter clock. Assumes clr is held whenever the converter is disabled.
*/
`timescale 1ns/100ps
`default_nettype none
`include "adccs_defines.svh"
module adccs_prescaler import adccs_pkg::*; (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic clr,
   input wire logic [2:0] div_sel,
   output logic rise,
   output logic half
);
   logic [6:0] cnt_q;
   logic [6:0] cnt_d;
   logic [7:0] ratio;

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   // Edges decoded from the count so a ratio change takes effect at once
   always_comb begin
      ratio = adccs_ratio(div_sel);
      rise = !clr && (cnt_q == 7'(ratio - 8'h01));
      half = !clr && (cnt_q == 7'((ratio >> 1) - 8'h01));
      cnt_d = cnt_q + 7'h01;
      if (clr || rise) begin
         cnt_d = 7'h00;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 7'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule
`default_nettype wire

// ==== verilog/adccs_device.sv ====
/*
 Converter sequencer, device end: control registers, conversion timing,
 selection buffering, result registers and sleep-started conversions.
 Assumes the analog core presents sar_result settled at completion.
*/
`timescale 1ns/100ps
`default_nettype none
`include "adccs_defines.svh"
// How it works
// - Software keeps converter clock 50-200 kHz
// - Converter clock comes from CPU clock prescaler
// - Prescaler runs only while enabled
// - Start waits for next converter clock rise
// - Normal: 13 cycles, sample at 1.5
// - First: 25 cycles, sample at 13.5
// - Completion stores result, sets flag, clears start unless free-running
// - Trigger resets prescaler; sample 2, 13.5 total
// - Two CPU cycles synchronise the trigger
// - Free-running restarts at once, 14 cycles
// - Selection buffered, locked during conversion
// - Selection copying resumes in last cycle
// - Software waits one cycle before new selection
// - Auto-trigger selection changes in safe windows
// - Free-running change hits the conversion after next
// - Software discards first result after reference switch
// - Quiet sleep starts a conversion
// - Completion still raises interrupt after early wake
// - Other sleep modes leave converter enabled
// - Start bit reads one during any conversion
// - Triggers during conversion are ignored
// - Low-byte read blocks result until high read
module adccs_device import adccs_pkg::*; (
   input wire logic mclk,
   input wire logic nrst,
   adccs_if.dev bus,
   input wire logic [9:0] sar_result,
   output logic sample_hold,
   output logic [3:0] chan_eff,
   output logic ref_eff
);
   logic en_q, en_d, start_q, start_d, auto_q, auto_d, flag_q, flag_d;
   logic ie_q, ie_d, free_q, free_d, ref_tmp_q, ref_tmp_d, ref_q, ref_d;
   logic lock_q, lock_d, first_q, first_d, irq_q, irq_d, sh_q, sh_d;
   logic [2:0] div_q, div_d;
   logic [3:0] ch_tmp_q, ch_tmp_d, ch_q, ch_d;
   logic [9:0] res_q, res_d;
   logic [7:0] rdata_q, rdata_d;
   logic [5:0] hcnt_q, hcnt_d, hnext;
   adccs_state_t st_q, st_d;
   adccs_kind_t kind_q, kind_d;
   logic trig_s1_q, trig_s2_q, trig_s3_q, sleep_prev_q;
   logic rise, half, auto_ev, sleep_ev, done, pre_clr;
   logic wr_a, wr_b, wr_sel, rd_lo, rd_hi;

   // ----------------------------------------------------------------
   // Profile lookup
   // ----------------------------------------------------------------
   function automatic logic [5:0] conv_len(input adccs_kind_t k);
      case (k)
         ADCCS_FIRST: conv_len = `ADCCS_FIRST_LEN;
         ADCCS_AUTO: conv_len = `ADCCS_AUTO_LEN;
         ADCCS_FREE: conv_len = `ADCCS_FREE_LEN;
         default: conv_len = `ADCCS_NORM_LEN;
      endcase
   endfunction

   function automatic logic [5:0] conv_sh(input adccs_kind_t k);
      case (k)
         ADCCS_FIRST: conv_sh = `ADCCS_FIRST_SH;
         ADCCS_AUTO: conv_sh = `ADCCS_AUTO_SH;
         ADCCS_FREE: conv_sh = `ADCCS_FREE_SH;
         default: conv_sh = `ADCCS_NORM_SH;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Prescaler
   // ----------------------------------------------------------------
   // Trigger event restarts the divider so the delay to sampling is fixed
   assign pre_clr = !en_q || auto_ev;

   adccs_prescaler u_pre (
      .mclk(mclk),
      .nrst(nrst),
      .clr(pre_clr),
      .div_sel(div_q),
      .rise(rise),
      .half(half)
   );

   // ----------------------------------------------------------------
   // Address decode and events
   // ----------------------------------------------------------------
   always_comb begin
      wr_a = 1'b0;
      wr_b = 1'b0;
      wr_sel = 1'b0;
      rd_lo = 1'b0;
      rd_hi = 1'b0;
      if (bus.io_addr == `ADCCS_OFS_CTRL_A) begin
         wr_a = bus.io_wr;
      end else if (bus.io_addr == `ADCCS_OFS_CTRL_B) begin
         wr_b = bus.io_wr;
      end else if (bus.io_addr == `ADCCS_OFS_SEL) begin
         wr_sel = bus.io_wr;
      end else if (bus.io_addr == `ADCCS_OFS_RES_LO) begin
         rd_lo = bus.io_rd;
      end else if (bus.io_addr == `ADCCS_OFS_RES_HI) begin
         rd_hi = bus.io_rd;
      end
      // Edge taken from the second stage against the third: two cycles of synchronisation
      auto_ev = en_q && auto_q && !free_q && trig_s2_q && !trig_s3_q
                && (st_q == ADCCS_IDLE);
      // Only a fresh entry into a quiet sleep mode starts a conversion
      sleep_ev = bus.sleep_quiet && !sleep_prev_q && en_q && !auto_q && ie_q
                 && !start_q && (st_q == ADCCS_IDLE);
   end

   // ----------------------------------------------------------------
   // Sequencer and register next values
   // ----------------------------------------------------------------
   always_comb begin
      en_d = en_q;
      start_d = start_q;
      auto_d = auto_q;
      flag_d = flag_q;
      ie_d = ie_q;
      free_d = free_q;
      div_d = div_q;
      ref_tmp_d = ref_tmp_q;
      ch_tmp_d = ch_tmp_q;
      ref_d = ref_q;
      ch_d = ch_q;
      res_d = res_q;
      lock_d = lock_q;
      first_d = first_q;
      hcnt_d = hcnt_q;
      st_d = st_q;
      kind_d = kind_q;
      sh_d = 1'b0;
      done = 1'b0;
      hnext = hcnt_q + 6'd1;
      rdata_d = rdata_q;
      if (!en_q) begin
         st_d = ADCCS_IDLE;
         first_d = 1'b1;
         hcnt_d = 6'd0;
      end else begin
         case (st_q)
            ADCCS_IDLE: begin
               ch_d = ch_tmp_q;
               ref_d = ref_tmp_q;
               hcnt_d = 6'd0;
               if (auto_ev) begin
                  st_d = ADCCS_CONV;
                  start_d = 1'b1;
                  kind_d = first_q ? ADCCS_FIRST : ADCCS_AUTO;
               end else if (start_q || sleep_ev) begin
                  st_d = ADCCS_WAIT;
                  start_d = 1'b1;
               end
            end
            ADCCS_WAIT: begin
               ch_d = ch_tmp_q;
               ref_d = ref_tmp_q;
               if (rise) begin
                  st_d = ADCCS_CONV;
                  kind_d = first_q ? ADCCS_FIRST : ADCCS_NORMAL;
               end
            end
            default: begin
               if (rise || half) begin
                  hcnt_d = hnext;
                  sh_d = (hnext == conv_sh(kind_q));
                  if (hnext >= conv_len(kind_q) - 6'd2) begin
                     ch_d = ch_tmp_q;
                     ref_d = ref_tmp_q;
                  end
                  if (hnext == conv_len(kind_q)) begin
                     done = 1'b1;
                     flag_d = 1'b1;
                     first_d = 1'b0;
                     hcnt_d = 6'd0;
                     if (!lock_q) begin
                        res_d = sar_result;
                     end
                     if (auto_q && free_q && start_q) begin
                        // Selection copied now only affects the one after
                        kind_d = ADCCS_FREE;
                     end else begin
                        st_d = ADCCS_IDLE;
                        start_d = 1'b0;
                     end
                  end
               end
            end
         endcase
      end
      // Software writes; hardware set of the flag wins over the clear
      if (wr_a) begin
         en_d = bus.io_wdata[`ADCCS_A_EN];
         auto_d = bus.io_wdata[`ADCCS_A_AUTO];
         ie_d = bus.io_wdata[`ADCCS_A_IE];
         div_d = bus.io_wdata[2:0];
         if (bus.io_wdata[`ADCCS_A_START]) begin
            start_d = 1'b1;
         end
         if (bus.io_wdata[`ADCCS_A_FLAG] && !done) begin
            flag_d = 1'b0;
         end
         if (!bus.io_wdata[`ADCCS_A_EN]) begin
            start_d = 1'b0;
         end
      end
      if (wr_b) begin
         free_d = bus.io_wdata[`ADCCS_B_FREE];
      end
      if (wr_sel) begin
         ref_tmp_d = bus.io_wdata[`ADCCS_SEL_REF];
         ch_tmp_d = bus.io_wdata[3:0];
      end
      // Read data and the low/high result interlock
      if (bus.io_rd) begin
         rdata_d = `ADCCS_RST_BYTE;
         if (bus.io_addr == `ADCCS_OFS_CTRL_A) begin
            rdata_d = {en_q, start_q, auto_q, flag_q, ie_q, div_q};
         end else if (bus.io_addr == `ADCCS_OFS_CTRL_B) begin
            rdata_d = {7'h00, free_q};
         end else if (bus.io_addr == `ADCCS_OFS_SEL) begin
            rdata_d = {1'b0, ref_tmp_q, 2'b00, ch_tmp_q};
         end else if (rd_lo) begin
            rdata_d = res_q[7:0];
            lock_d = 1'b1;
         end else if (rd_hi) begin
            rdata_d = {6'h00, res_q[9:8]};
            lock_d = 1'b0;
         end
      end
      irq_d = flag_d && ie_d;
   end

   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         en_q <= 1'b0;
         start_q <= 1'b0;
         auto_q <= 1'b0;
         flag_q <= 1'b0;
         ie_q <= 1'b0;
         free_q <= 1'b0;
         div_q <= 3'h0;
         ref_tmp_q <= 1'b0;
         ch_tmp_q <= 4'h0;
         ref_q <= 1'b0;
         ch_q <= 4'h0;
         res_q <= 10'h000;
         lock_q <= 1'b0;
         first_q <= 1'b1;
         hcnt_q <= 6'd0;
         st_q <= ADCCS_IDLE;
         kind_q <= ADCCS_FIRST;
         sh_q <= 1'b0;
         rdata_q <= `ADCCS_RST_BYTE;
         irq_q <= 1'b0;
         trig_s1_q <= 1'b0;
         trig_s2_q <= 1'b0;
         trig_s3_q <= 1'b0;
         sleep_prev_q <= 1'b0;
      end else begin
         en_q <= en_d;
         start_q <= start_d;
         auto_q <= auto_d;
         flag_q <= flag_d;
         ie_q <= ie_d;
         free_q <= free_d;
         div_q <= div_d;
         ref_tmp_q <= ref_tmp_d;
         ch_tmp_q <= ch_tmp_d;
         ref_q <= ref_d;
         ch_q <= ch_d;
         res_q <= res_d;
         lock_q <= lock_d;
         first_q <= first_d;
         hcnt_q <= hcnt_d;
         st_q <= st_d;
         kind_q <= kind_d;
         sh_q <= sh_d;
         rdata_q <= rdata_d;
         irq_q <= irq_d;
         trig_s1_q <= bus.trig_src;
         trig_s2_q <= trig_s1_q;
         trig_s3_q <= trig_s2_q;
         sleep_prev_q <= bus.sleep_quiet;
      end
   end

   assign bus.io_rdata = rdata_q;
   assign bus.conv_irq = irq_q;
   assign sample_hold = sh_q;
   assign chan_eff = ch_q;
   assign ref_eff = ref_q;
endmodule
`default_nettype wire

// ==== verilog/adccs_host.sv ====
/*
 CPU-side end: turns user commands into I/O strobes, paces selection
 writes and marks results taken right after a reference switch.
 Assumes the device answers reads one cycle after the strobe.
*/
`timescale 1ns/100ps
`default_nettype none
`include "adccs_defines.svh"
module adccs_host import adccs_pkg::*; (
   input wire logic mclk,
   input wire logic nrst,
   adccs_if.host bus,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [5:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_stale,
   input wire logic trig_in,
   input wire logic sleep_in,
   output logic irq
);
   adccs_hstate_t st_q, st_d;
   logic [5:0] addr_q, addr_d;
   logic [7:0] wdata_q, wdata_d, rsp_q, rsp_d;
   logic wr_q, wr_d, rd_q, rd_d, rdy_q, rdy_d, rv_q, rv_d, stale_q, stale_d;
   logic [2:0] div_q, div_d;
   logic auto_q, auto_d, ref_q, ref_d, pend_q, pend_d;
   logic trig_q, sleep_q, irq_q, trig_prev_q;
   logic [8:0] hold_q, hold_d;
   logic take, is_sel;

   // ----------------------------------------------------------------
   // Command sequencing and pacing
   // ----------------------------------------------------------------
   // Whole port stalls while pacing; simpler than filtering by address
   always_comb begin
      st_d = st_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      wr_d = 1'b0;
      rd_d = 1'b0;
      rv_d = 1'b0;
      rsp_d = rsp_q;
      stale_d = stale_q;
      div_d = div_q;
      auto_d = auto_q;
      ref_d = ref_q;
      pend_d = pend_q;
      hold_d = (hold_q != 9'h000) ? hold_q - 9'h001 : hold_q;
      take = cmd_valid && rdy_q;
      is_sel = cmd_write && (cmd_addr == `ADCCS_OFS_SEL);
      // Two converter cycles cover the wait for the start edge plus one
      if (auto_q && trig_q && !trig_prev_q) begin
         hold_d = {adccs_ratio(div_q), 1'b0};
      end
      case (st_q)
         ADCCS_H_IDLE: begin
            if (take) begin
               st_d = ADCCS_H_STROBE;
               addr_d = cmd_addr;
               wdata_d = cmd_wdata;
               wr_d = cmd_write;
               rd_d = !cmd_write;
               if (cmd_write && cmd_addr == `ADCCS_OFS_CTRL_A) begin
                  div_d = cmd_wdata[2:0];
                  auto_d = cmd_wdata[`ADCCS_A_AUTO];
                  if (cmd_wdata[`ADCCS_A_START]) begin
                     hold_d = {adccs_ratio(cmd_wdata[2:0]), 1'b0};
                  end
               end
               if (is_sel && cmd_wdata[`ADCCS_SEL_REF] != ref_q) begin
                  ref_d = cmd_wdata[`ADCCS_SEL_REF];
                  pend_d = 1'b1;
               end
            end
         end
         ADCCS_H_STROBE: begin
            st_d = ADCCS_H_CAPT;
         end
         default: begin
            st_d = ADCCS_H_IDLE;
            rv_d = 1'b1;
            rsp_d = bus.io_rdata;
            stale_d = 1'b0;
            if (!wr_q && addr_q == `ADCCS_OFS_RES_HI) begin
               stale_d = pend_q;
               pend_d = 1'b0;
            end
         end
      endcase
      rdy_d = (st_d == ADCCS_H_IDLE) && (hold_d == 9'h000) && !take;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_q <= ADCCS_H_IDLE;
         addr_q <= 6'h00;
         wdata_q <= 8'h00;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         rdy_q <= 1'b0;
         rv_q <= 1'b0;
         rsp_q <= 8'h00;
         stale_q <= 1'b0;
         div_q <= 3'h0;
         auto_q <= 1'b0;
         ref_q <= 1'b0;
         pend_q <= 1'b0;
         hold_q <= 9'h000;
         trig_q <= 1'b0;
         trig_prev_q <= 1'b0;
         sleep_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         st_q <= st_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         rdy_q <= rdy_d;
         rv_q <= rv_d;
         rsp_q <= rsp_d;
         stale_q <= stale_d;
         div_q <= div_d;
         auto_q <= auto_d;
         ref_q <= ref_d;
         pend_q <= pend_d;
         hold_q <= hold_d;
         trig_q <= trig_in;
         trig_prev_q <= trig_q;
         sleep_q <= sleep_in;
         irq_q <= bus.conv_irq;
      end
   end

   assign bus.io_addr = addr_q;
   assign bus.io_wdata = wdata_q;
   assign bus.io_wr = wr_q;
   assign bus.io_rd = rd_q;
   assign bus.trig_src = trig_q;
   assign bus.sleep_quiet = sleep_q;
   assign cmd_ready = rdy_q;
   assign rsp_valid = rv_q;
   assign rsp_data = rsp_q;
   assign rsp_stale = stale_q;
   assign irq = irq_q;
endmodule
`default_nettype wire

// ==== verification/adccs_assertions.sv ====
/*
 Concurrent checks on the bus joining the host and device ends.
 Assumes one clock; instanced beside the interface.
*/
`timescale 1ns/100ps
`default_nettype none
`include "adccs_defines.svh"
module adccs_assertions (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [5:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_rdata,
   input wire logic trig_src,
   input wire logic sleep_quiet,
   input wire logic conv_irq
);
   // --------
   // Shadow state
   // --------
   logic wr_a, rd_lo, rd_hi;
   logic ie_q, ie_d, rdl_q, rdl_d, lk_q, lk_d;
   logic [7:0] lo_q, lo_d;
   assign wr_a = io_wr && (io_addr == `ADCCS_OFS_CTRL_A);
   assign rd_lo = io_rd && (io_addr == `ADCCS_OFS_RES_LO);
   assign rd_hi = io_rd && (io_addr == `ADCCS_OFS_RES_HI);
   // First low byte after unlock is kept; later low reads must repeat it
   always_comb begin
      ie_d = wr_a ? io_wdata[`ADCCS_A_IE] : ie_q;
      rdl_d = rd_lo;
      lk_d = rd_hi ? 1'b0 : (lk_q || rdl_q);
      lo_d = (rdl_q && !lk_q) ? io_rdata : lo_q;
   end
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ie_q <= 1'b0;
         rdl_q <= 1'b0;
         lk_q <= 1'b0;
         lo_q <= 8'h00;
      end else begin
         ie_q <= ie_d;
         rdl_q <= rdl_d;
         lk_q <= lk_d;
         lo_q <= lo_d;
      end
   end
   // --------
   // Properties
   // --------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   AST_RD_UNMAPPED: assert property (io_rd && io_addr == 6'h3f |=> io_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_HI_UPPER: assert property (rd_hi |=> io_rdata[7:2] == 6'h00)
      else $error("result high byte upper bits set");
   AST_LO_LOCKED: assert property (rdl_q && lk_q |-> io_rdata == lo_q)
      else $error("low byte changed while locked");
   AST_STROBE_GAP: assert property ((io_wr || io_rd) |=> !(io_wr || io_rd) [*3])
      else $error("bus strobes too close");
   AST_RDATA_HOLD: assert property (!io_rd |=> $stable(io_rdata))
      else $error("read data moved without a read");
   AST_IRQ_NEEDS_IE: assert property (conv_irq |-> ie_q || $past(ie_q))
      else $error("interrupt with enable off");
   AST_IRQ_HELD: assert property ($fell(conv_irq) |-> $past(wr_a) || $past(wr_a, 2))
      else $error("interrupt dropped without a write");
   AST_START_PACE: assert property (wr_a && io_wdata[`ADCCS_A_START] |=> !io_wr [*4])
      else $error("write too soon after start");
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
/*
 Self-checking bench: host and device ends joined by the interface.
 Assumes the design headers on the include path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "adccs_defines.svh"
module tb_top;
   // --------
   // Design, clock and monitors
   // --------
   localparam logic [7:0] EN = 8'h01 << `ADCCS_A_EN, ST = 8'h01 << `ADCCS_A_START;
   localparam logic [7:0] AU = 8'h01 << `ADCCS_A_AUTO, FL = 8'h01 << `ADCCS_A_FLAG;
   localparam logic [7:0] IE = 8'h01 << `ADCCS_A_IE;
   logic mclk, nrst, cmd_valid, cmd_write, cmd_ready, rsp_valid, rsp_stale;
   logic trig_in, sleep_in, irq, sample_hold, ref_eff;
   logic [5:0] cmd_addr;
   logic [7:0] cmd_wdata, rsp_data, q;
   logic [9:0] sar_result, res;
   logic [3:0] chan_eff;
   logic [5:0] adr [6] = '{6'h06, 6'h03, 6'h10, 6'h04, 6'h05, 6'h3f};
   int n_fail, n_checks, cyc, sh_n, sh_last, sh_prev, seed, t0, r, d, k, n0;
   adccs_if u_adccs_if ();
   adccs_host u_adccs_host (.mclk(mclk), .nrst(nrst), .bus(u_adccs_if.host),
      .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_stale(rsp_stale), .trig_in(trig_in),
      .sleep_in(sleep_in), .irq(irq));
   adccs_device u_adccs_device (.mclk(mclk), .nrst(nrst), .bus(u_adccs_if.dev),
      .sar_result(sar_result), .sample_hold(sample_hold), .chan_eff(chan_eff),
      .ref_eff(ref_eff));
   adccs_assertions u_adccs_assertions (.mclk(mclk), .nrst(nrst),
      .io_addr(u_adccs_if.io_addr), .io_wdata(u_adccs_if.io_wdata),
      .io_wr(u_adccs_if.io_wr), .io_rd(u_adccs_if.io_rd),
      .io_rdata(u_adccs_if.io_rdata), .trig_src(u_adccs_if.trig_src),
      .sleep_quiet(u_adccs_if.sleep_quiet), .conv_irq(u_adccs_if.conv_irq));
   always #2.5 mclk = ~mclk;
   // Cycle count and sample-and-hold time stamps
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (sample_hold === 1'b1) begin
         sh_n <= sh_n + 1;
         sh_prev <= sh_last;
         sh_last <= cyc;
      end
   end
   // --------
   // Tasks
   // --------
   task automatic print_verdict();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic bail();
      n_fail++;
      $display("[ERR] wait timed out");
      print_verdict();
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   // One command; ready only counts at an edge where the request stands
   task automatic cmd(input logic w, input logic [5:0] a, input logic [7:0] dt);
      int i;
      {cmd_valid, cmd_write, cmd_addr, cmd_wdata} <= {1'b1, w, a, dt};
      @(posedge mclk);
      for (i = 0; i < 999 && cmd_ready !== 1'b1; i++) @(posedge mclk);
      if (cmd_ready !== 1'b1) bail();
      cmd_valid <= 1'b0;
      i = 0;
      do begin
         @(posedge mclk);
         i++;
      end while (rsp_valid !== 1'b1 && i < 9);
      if (rsp_valid !== 1'b1) bail();
      q = rsp_data;
   endtask
   task automatic wait_irq();
      int i;
      for (i = 0; i < 40000 && irq !== 1'b1; i++) @(posedge mclk);
      if (irq !== 1'b1) bail();
   endtask
   task automatic wait_sh();
      int i, m;
      m = sh_n;
      for (i = 0; i < 200 && sh_n == m; i++) @(posedge mclk);
      if (sh_n == m) bail();
   endtask
   // --------
   // Sequence
   // --------
   initial begin
      {mclk, nrst, cmd_valid, cmd_write, trig_in, sleep_in} = '0;
      {cmd_addr, cmd_wdata, sar_result, cyc, sh_n, sh_last, sh_prev, n_fail, n_checks} = '0;
      seed = 94129;
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      // Reset values; result write and unmapped place refused
      cmd(1'b1, `ADCCS_OFS_RES_LO, 8'hff);
      foreach (adr[i]) begin
         cmd(1'b0, adr[i], 8'h00);
         chk("reset value", 8'h00, q);
      end
      // Every divider code: first then normal conversion length
      for (d = 0; d < 8; d++) begin
         r = (d == 0) ? 2 : (1 << d);
         cmd(1'b1, `ADCCS_OFS_CTRL_A, 8'h00);
         for (k = 0; k < 2; k++) begin
            res = 10'($random(seed));
            sar_result <= res;
            cmd(1'b1, `ADCCS_OFS_CTRL_A, EN | IE | FL | 8'(d));
            cmd(1'b1, `ADCCS_OFS_CTRL_A, EN | ST | IE | 8'(d));
            t0 = cyc;
            cmd(1'b0, `ADCCS_OFS_CTRL_A, 8'h00);
            chk("start busy", 1'b1, q[`ADCCS_A_START]);
            wait_irq();
            t0 = (k ? 13 : 25) * r - (cyc - t0);
            chk("conv length", 1'b1, t0 <= 4 && t0 >= -r - 6);
            cmd(1'b0, `ADCCS_OFS_CTRL_A, 8'h00);
            chk("flag start", FL, q & (FL | ST));
            cmd(1'b0, `ADCCS_OFS_RES_LO, 8'h00);
            chk("result low", res[7:0], q);
            cmd(1'b0, `ADCCS_OFS_RES_HI, 8'h00);
            chk("result high", {6'h00, res[9:8]}, q);
         end
      end
      // Low read locks; a completion meanwhile is lost but flagged
      cmd(1'b0, `ADCCS_OFS_RES_LO, 8'h00);
      sar_result <= ~res;
      cmd(1'b1, `ADCCS_OFS_CTRL_A, EN | ST | IE | FL);
      wait_irq();
      cmd(1'b0, `ADCCS_OFS_RES_LO, 8'h00);
      chk("locked low", res[7:0], q);
      cmd(1'b0, `ADCCS_OFS_RES_HI, 8'h00);
      chk("locked high", {6'h00, res[9:8]}, q);
      // Free running; channel written after a completion
      cmd(1'b1, `ADCCS_OFS_SEL, 8'h43);
      cmd(1'b1, `ADCCS_OFS_CTRL_B, 8'h01);
      cmd(1'b1, `ADCCS_OFS_CTRL_A, EN | ST | AU | IE | FL);
      wait_sh();
      wait_sh();
      chk("free period", 16'd28, 16'(sh_last - sh_prev));
      cmd(1'b1, `ADCCS_OFS_SEL, 8'h05);
      chk("chan locked", 5'h13, {ref_eff, chan_eff});
      wait_sh();
      chk("chan next", 5'h05, {ref_eff, chan_eff});
      cmd(1'b1, `ADCCS_OFS_CTRL_A, 8'h00);
      cmd(1'b1, `ADCCS_OFS_CTRL_B, 8'h00);
      // Auto trigger after a first conversion; second edge ignored
      cmd(1'b1, `ADCCS_OFS_CTRL_A, EN | ST | IE | FL);
      wait_irq();
      cmd(1'b1, `ADCCS_OFS_CTRL_A, EN | AU | IE | FL);
      n0 = sh_n;
      trig_in <= 1'b1;
      t0 = cyc;
      wait_sh();
      chk("trig delay", 1'b1, sh_last - t0 >= 5 && sh_last - t0 <= 12);
      trig_in <= 1'b0;
      repeat (3) @(posedge mclk);
      trig_in <= 1'b1;
      repeat (60) @(posedge mclk);
      chk("trig count", 16'(n0 + 1), 16'(sh_n));
      trig_in <= 1'b0;
      // Quiet sleep starts one conversion that raises the interrupt
      cmd(1'b1, `ADCCS_OFS_CTRL_A, EN | IE | FL);
      n0 = sh_n;
      sleep_in <= 1'b1;
      wait_irq();
      chk("sleep conv", 16'(n0 + 1), 16'(sh_n));
      sleep_in <= 1'b0;
      cmd(1'b0, `ADCCS_OFS_RES_HI, 8'h00);
      chk("stale", 1'b1, rsp_stale);
      print_verdict();
   end
endmodule
`default_nettype wire
